// ### rtl/fp_context_control_reg.sv
// Floating-point context control register with APB access, security
// banking and the control outputs that steer floating-point state handling.
// Assumes event pulses come from core logic on pclk; pprot[1] high marks a
// Non-secure access.
`timescale 1ns/10ps
module fp_context_control_reg
	import fp_ctx_pkg::*;
#(
	parameter bit          SECURITY_EXT = 1'b1,
	parameter logic [31:0] RESET_VALUE  = fp_ctx_pkg::CTRL_RESET
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire fp_ctx_pkg::apb_req_t    apb_req,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    frame_alloc,
	input  wire logic                    frame_secure,
	input  wire fp_ctx_pkg::frame_info_t frame_info,
	input  wire logic                    fp_instr_exec,
	input  wire logic                    exec_secure,
	input  wire logic                    lazy_save_done,
	input  wire logic                    exc_return,
	input  wire logic                    fp_context_clear,
	input  wire logic                    secure_debug_monitor_enable,
	input  wire logic                    bus_fault_ns_enable,
	output logic                         fp_context_active_flag,
	output logic                         clear_caller_regs,
	output logic                         lazy_skip_mem,
	output logic                         lazy_zero_regs,
	output logic                         fp_regs_secure,
	output logic                         lazy_save_enable_out
);
	import fp_ctx_pkg::*;

	localparam int NUM_BANKS = SECURITY_EXT ? 2 : 1;

	// Shared state
	logic lazy_save_enable_reg;
	logic lazy_save_enable_lock_reg;
	logic clear_on_return_reg;
	logic clear_on_return_lock_reg;
	logic treat_fp_secure_reg;
	logic hard_fault_ready_reg;
	logic bus_fault_ready_reg;
	logic debug_monitor_ready_reg;
	logic secure_fault_ready_reg;
	logic ctx_secure_reg;
	logic fpca_reg;
	logic clear_pulse_reg;
	logic [31:0] rdata_reg;

	// Bus decode
	logic        ns_access;
	logic        addr_hit;
	logic        setup;
	logic        wr_go;
	logic [31:0] strb_mask;
	logic [31:0] read_mask;
	logic [31:0] write_mask;
	logic [31:0] wr_bits;
	logic [31:0] view;
	logic        acc_bank;
	logic        own_bank;

	bank_state_t bank [NUM_BANKS];

	// Without the extension every access sees the single, secure bank
	assign ns_access = SECURITY_EXT && apb_req.pprot[1];
	assign acc_bank  = SECURITY_EXT && ns_access;
	assign own_bank  = SECURITY_EXT && !ctx_secure_reg;
	assign addr_hit  = (apb_req.paddr[APB_ADDR_W-1:2] == FP_CTX_CTRL_OFF[APB_ADDR_W-1:2]);
	assign setup     = apb_req.psel && !apb_req.penable;
	assign wr_go     = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_hit;
	assign strb_mask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
	                    {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

	// Visibility of each bit to the current accessor
	always_comb begin
		read_mask = IMPL_MASK;
		if (!SECURITY_EXT || ns_access) begin
			read_mask = read_mask & ~SEC_ONLY_MASK;
		end
		if (ns_access && secure_debug_monitor_enable) begin
			read_mask[POS_DBG_MON_RDY] = 1'b0;
		end
		if (ns_access && !bus_fault_ns_enable) begin
			read_mask[POS_BUS_FAULT_RDY] = 1'b0;
			read_mask[POS_HARD_RDY]      = 1'b0;
		end
	end

	// Locked bits stay readable but drop out of the Non-secure write mask
	always_comb begin
		write_mask = read_mask;
		if (ns_access && lazy_save_enable_lock_reg) begin
			write_mask[POS_LAZY_EN] = 1'b0;
		end
		if (ns_access && clear_on_return_lock_reg) begin
			write_mask[POS_CLR_RET] = 1'b0;
		end
	end

	assign wr_bits = write_mask & strb_mask & {32{wr_go}};

	// Banked part, one copy per security state
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic [31:0] bank_wr;
			logic        bank_cap;
			logic        bank_done;
			assign bank_wr   = (int'(acc_bank) == b) ? wr_bits : 32'h00000000;
			assign bank_cap  = frame_alloc && (int'(SECURITY_EXT && !frame_secure) == b);
			assign bank_done = lazy_save_done && (int'(own_bank) == b);
			fp_bank_status #(
				.RESET_VALUE (RESET_VALUE)
			) u_bank (
				.pclk      (pclk),
				.presetn   (presetn),
				.wr_mask   (bank_wr),
				.wdata     (apb_req.pwdata),
				.capture   (bank_cap),
				.info      (frame_info),
				.lazy_arm  (lazy_save_enable_reg && fpca_reg),
				.lazy_done (bank_done),
				.state     (bank[b])
			);
		end
	endgenerate

	// Shared enables and locks, software owned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lazy_save_enable_reg      <= RESET_VALUE[POS_LAZY_EN];
			lazy_save_enable_lock_reg <= SECURITY_EXT & RESET_VALUE[POS_LAZY_EN_LOCK];
			clear_on_return_reg       <= RESET_VALUE[POS_CLR_RET];
			clear_on_return_lock_reg  <= SECURITY_EXT & RESET_VALUE[POS_CLR_RET_LOCK];
			treat_fp_secure_reg       <= SECURITY_EXT & RESET_VALUE[POS_TREAT_SECURE];
		end else begin
			if (wr_bits[POS_LAZY_EN])      lazy_save_enable_reg      <= apb_req.pwdata[POS_LAZY_EN];
			if (wr_bits[POS_LAZY_EN_LOCK]) lazy_save_enable_lock_reg <= apb_req.pwdata[POS_LAZY_EN_LOCK];
			if (wr_bits[POS_CLR_RET])      clear_on_return_reg       <= apb_req.pwdata[POS_CLR_RET];
			if (wr_bits[POS_CLR_RET_LOCK]) clear_on_return_lock_reg  <= apb_req.pwdata[POS_CLR_RET_LOCK];
			if (wr_bits[POS_TREAT_SECURE]) treat_fp_secure_reg       <= apb_req.pwdata[POS_TREAT_SECURE];
		end
	end

	// Shared frame status; hardware capture wins over a same-cycle write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hard_fault_ready_reg    <= RESET_VALUE[POS_HARD_RDY];
			bus_fault_ready_reg     <= RESET_VALUE[POS_BUS_FAULT_RDY];
			debug_monitor_ready_reg <= RESET_VALUE[POS_DBG_MON_RDY];
			secure_fault_ready_reg  <= SECURITY_EXT & RESET_VALUE[POS_SEC_FAULT_RDY];
		end else if (frame_alloc) begin
			hard_fault_ready_reg    <= frame_info.hard_fault_ready;
			bus_fault_ready_reg     <= frame_info.bus_fault_ready;
			debug_monitor_ready_reg <= frame_info.debug_monitor_ready;
			secure_fault_ready_reg  <= SECURITY_EXT & frame_info.secure_fault_ready;
		end else begin
			if (wr_bits[POS_HARD_RDY])      hard_fault_ready_reg    <= apb_req.pwdata[POS_HARD_RDY];
			if (wr_bits[POS_BUS_FAULT_RDY]) bus_fault_ready_reg     <= apb_req.pwdata[POS_BUS_FAULT_RDY];
			if (wr_bits[POS_DBG_MON_RDY])   debug_monitor_ready_reg <= apb_req.pwdata[POS_DBG_MON_RDY];
			if (wr_bits[POS_SEC_FAULT_RDY]) secure_fault_ready_reg  <= apb_req.pwdata[POS_SEC_FAULT_RDY];
		end
	end

	// Context ownership: instruction execution outranks lazy arming, then writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctx_secure_reg <= SECURITY_EXT & RESET_VALUE[POS_CTX_SECURE];
		end else if (fp_instr_exec) begin
			ctx_secure_reg <= SECURITY_EXT & exec_secure;
		end else if (frame_alloc && lazy_save_enable_reg && fpca_reg) begin
			ctx_secure_reg <= SECURITY_EXT & frame_secure;
		end else if (wr_bits[POS_CTX_SECURE]) begin
			ctx_secure_reg <= apb_req.pwdata[POS_CTX_SECURE];
		end
	end

	// Context-active flag; the setting event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fpca_reg <= 1'b0;
		end else if (fp_instr_exec && bank[int'(SECURITY_EXT && !exec_secure)].auto_preserve_enable) begin
			fpca_reg <= 1'b1;
		end else if (fp_context_clear) begin
			fpca_reg <= 1'b0;
		end
	end

	// Caller register clear request, one pulse per return or tail chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_pulse_reg <= 1'b0;
		end else begin
			clear_pulse_reg <= exc_return && clear_on_return_reg && fpca_reg
			                   && !bank[BANK_SEC].lazy_save_active;
		end
	end

	// Register view before masking
	always_comb begin
		view                    = 32'h00000000;
		view[POS_AUTO_PRESERVE] = bank[int'(acc_bank)].auto_preserve_enable;
		view[POS_LAZY_EN]       = lazy_save_enable_reg;
		view[POS_LAZY_EN_LOCK]  = lazy_save_enable_lock_reg;
		view[POS_CLR_RET]       = clear_on_return_reg;
		view[POS_CLR_RET_LOCK]  = clear_on_return_lock_reg;
		view[POS_TREAT_SECURE]  = treat_fp_secure_reg;
		view[POS_USAGE_RDY]     = bank[int'(acc_bank)].usage_fault_ready;
		view[POS_STACK_VIOL]    = bank[int'(acc_bank)].stack_limit_violation;
		view[POS_DBG_MON_RDY]   = debug_monitor_ready_reg;
		view[POS_SEC_FAULT_RDY] = secure_fault_ready_reg;
		view[POS_BUS_FAULT_RDY] = bus_fault_ready_reg;
		view[POS_MEM_MAN_RDY]   = bank[int'(acc_bank)].mem_manage_ready;
		view[POS_HARD_RDY]      = hard_fault_ready_reg;
		view[POS_THREAD]        = bank[int'(acc_bank)].thread_mode;
		view[POS_CTX_SECURE]    = ctx_secure_reg;
		view[POS_UNPRIV]        = bank[int'(acc_bank)].unprivileged;
		view[POS_LAZY_ACTIVE]   = bank[int'(acc_bank)].lazy_save_active;
	end

	// Read data sampled in the setup cycle, so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h00000000;
		end else if (setup) begin
			rdata_reg <= (addr_hit && !apb_req.pwrite) ? (view & read_mask) : 32'h00000000;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error and no effect
	assign prdata  = rdata_reg;
	assign pready  = 1'b1;
	assign pslverr = apb_req.psel && apb_req.penable && !addr_hit;

	// Control outputs to the floating-point sequencer
	assign fp_context_active_flag = fpca_reg;
	assign clear_caller_regs      = clear_pulse_reg;
	assign lazy_skip_mem          = bank[int'(own_bank)].lazy_save_active
	                                && bank[int'(own_bank)].stack_limit_violation;
	assign lazy_zero_regs         = lazy_skip_mem && ctx_secure_reg && treat_fp_secure_reg;
	assign fp_regs_secure         = treat_fp_secure_reg;
	assign lazy_save_enable_out   = lazy_save_enable_reg;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lazy_lock_hold_a: assert property (
		(wr_go && ns_access && lazy_save_enable_lock_reg) |=> $stable(lazy_save_enable_reg))
		else $error("lazy-save enable changed by locked Non-secure write");
	lazy_lock_write_a: assert property (
		(wr_go && !ns_access && apb_req.pstrb[3]) |=> lazy_save_enable_reg == $past(apb_req.pwdata[POS_LAZY_EN]))
		else $error("Secure write to lazy-save enable lost");
	clear_return_a: assert property (
		(exc_return && clear_on_return_reg && fpca_reg && !bank[BANK_SEC].lazy_save_active)
		|=> clear_caller_regs ##1 (!clear_caller_regs || $past(exc_return)))
		else $error("caller clear pulse wrong");
	clear_guard_a: assert property (
		clear_caller_regs |-> $past(exc_return && fpca_reg && clear_on_return_reg))
		else $error("caller clear without cause");
	ret_lock_hold_a: assert property (
		(wr_go && ns_access && clear_on_return_lock_reg) |=> $stable(clear_on_return_reg))
		else $error("clear-on-return changed under lock");
	ns_hidden_a: assert property (
		(setup && ns_access) |=> (rdata_reg & SEC_ONLY_MASK) == 32'h00000000)
		else $error("Secure-only bit visible to Non-secure");
	reserved_zero_a: assert property (
		(rdata_reg & ~IMPL_MASK) == 32'h00000000)
		else $error("reserved bits read nonzero");
	fpca_set_a: assert property (
		(fp_instr_exec && bank[int'(SECURITY_EXT && !exec_secure)].auto_preserve_enable) |=> fpca_reg)
		else $error("context-active flag not set");
	fpca_rise_a: assert property (
		$rose(fpca_reg) |-> $past(fp_instr_exec))
		else $error("context-active flag rose without instruction");
	hard_cap_a: assert property (
		frame_alloc |=> hard_fault_ready_reg == $past(frame_info.hard_fault_ready))
		else $error("HardFault readiness not captured");
	monitor_hide_a: assert property (
		(setup && ns_access && secure_debug_monitor_enable) |=> !rdata_reg[POS_DBG_MON_RDY])
		else $error("monitor readiness visible under secure monitor");
	zero_regs_a: assert property (
		(bank[BANK_SEC].lazy_save_active && bank[BANK_SEC].stack_limit_violation && ctx_secure_reg
		 && treat_fp_secure_reg) |-> lazy_zero_regs)
		else $error("register zeroing missing");

	// Lazy state, context ownership, frame capture and fault visibility
	lazy_arm_a: assert property (
		(frame_alloc && (frame_secure || !SECURITY_EXT) && lazy_save_enable_reg && fpca_reg)
		|=> bank[BANK_SEC].lazy_save_active)
		else $error("lazy-active not set on arming");
	lazy_done_a: assert property (
		(lazy_save_done && !frame_alloc && !own_bank) |=> !bank[BANK_SEC].lazy_save_active)
		else $error("lazy-active not cleared after save");
	skip_mem_a: assert property (
		(bank[BANK_SEC].lazy_save_active && bank[BANK_SEC].stack_limit_violation && !own_bank) |-> lazy_skip_mem)
		else $error("deferred save not skipped on violation");
	ctx_exec_a: assert property (
		fp_instr_exec |=> ctx_secure_reg == (SECURITY_EXT && $past(exec_secure)))
		else $error("context security not updated by instruction");
	thread_cap_a: assert property (
		(frame_alloc && (frame_secure || !SECURITY_EXT))
		|=> bank[BANK_SEC].thread_mode == $past(frame_info.thread_mode))
		else $error("Thread mode not captured");
	usage_cap_a: assert property (
		(frame_alloc && (frame_secure || !SECURITY_EXT))
		|=> bank[BANK_SEC].usage_fault_ready == $past(frame_info.usage_fault_ready))
		else $error("UsageFault readiness not captured");
	bus_hide_a: assert property (
		(setup && ns_access && !bus_fault_ns_enable) |=> !rdata_reg[POS_BUS_FAULT_RDY] && !rdata_reg[POS_HARD_RDY])
		else $error("fault readiness visible to Non-secure");

	cover_ns_locked_c: cover property (wr_go && ns_access && lazy_save_enable_lock_reg);
	cover_clear_c:     cover property (clear_caller_regs);
	cover_lazy_c:      cover property (frame_alloc && lazy_save_enable_reg && fpca_reg ##1 lazy_save_done);
	cover_err_c:       cover property (pslverr);

endmodule : fp_context_control_reg

// ### rtl/fp_ctx_pkg.sv
// Constants, field positions and carrier types for the floating-point
// context control register. Assumes an APB slave with 32-bit data.
package fp_ctx_pkg;

	// Register placement on the bus
	localparam int          APB_ADDR_W      = 12;
	localparam logic [11:0] FP_CTX_CTRL_OFF = 12'h000;

	// Field positions
	localparam int POS_AUTO_PRESERVE = 31;
	localparam int POS_LAZY_EN       = 30;
	localparam int POS_LAZY_EN_LOCK  = 29;
	localparam int POS_CLR_RET       = 28;
	localparam int POS_CLR_RET_LOCK  = 27;
	localparam int POS_TREAT_SECURE  = 26;
	localparam int POS_USAGE_RDY     = 10;
	localparam int POS_STACK_VIOL    = 9;
	localparam int POS_DBG_MON_RDY   = 8;
	localparam int POS_SEC_FAULT_RDY = 7;
	localparam int POS_BUS_FAULT_RDY = 6;
	localparam int POS_MEM_MAN_RDY   = 5;
	localparam int POS_HARD_RDY      = 4;
	localparam int POS_THREAD        = 3;
	localparam int POS_CTX_SECURE    = 2;
	localparam int POS_UNPRIV        = 1;
	localparam int POS_LAZY_ACTIVE   = 0;

	// Implemented bits; 25..11 read as zero
	localparam logic [31:0] IMPL_MASK     = 32'hFC0007FF;
	// Bits only the secure view may see
	localparam logic [31:0] SEC_ONLY_MASK = 32'h2C000084;
	// Register value after reset
	localparam logic [31:0] CTRL_RESET    = 32'h00000000;

	// Bank numbers; without the security extension only bank 0 exists
	localparam int BANK_SEC = 0;
	localparam int BANK_NS  = 1;

	// APB request as seen by the slave
	typedef struct packed {
		logic [APB_ADDR_W-1:0] paddr;
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [31:0]           pwdata;
		logic [3:0]            pstrb;
		logic [2:0]            pprot;
	} apb_req_t;

	// Status sampled when a floating-point stack frame is allocated
	typedef struct packed {
		logic usage_fault_ready;
		logic debug_monitor_ready;
		logic secure_fault_ready;
		logic bus_fault_ready;
		logic mem_manage_ready;
		logic hard_fault_ready;
		logic thread_mode;
		logic unprivileged;
		logic stack_limit_violation;
	} frame_info_t;

	// Per-bank register state
	typedef struct packed {
		logic auto_preserve_enable;
		logic stack_limit_violation;
		logic thread_mode;
		logic usage_fault_ready;
		logic mem_manage_ready;
		logic unprivileged;
		logic lazy_save_active;
	} bank_state_t;

endpackage : fp_ctx_pkg

// ### rtl/fp_bank_status.sv
// One security bank of the context control register: banked enable and
// frame status bits. Assumes write masks already checked for access rights.
`timescale 1ns/10ps
module fp_bank_status
	import fp_ctx_pkg::*;
#(
	parameter logic [31:0] RESET_VALUE = CTRL_RESET
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [31:0]             wr_mask,
	input  wire logic [31:0]             wdata,
	input  wire logic                    capture,
	input  wire fp_ctx_pkg::frame_info_t info,
	input  wire logic                    lazy_arm,
	input  wire logic                    lazy_done,
	output fp_ctx_pkg::bank_state_t      state
);

	// Software-owned enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.auto_preserve_enable <= RESET_VALUE[POS_AUTO_PRESERVE];
		end else if (wr_mask[POS_AUTO_PRESERVE]) begin
			state.auto_preserve_enable <= wdata[POS_AUTO_PRESERVE];
		end
	end

	// Frame capture wins over a write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.stack_limit_violation <= RESET_VALUE[POS_STACK_VIOL];
			state.thread_mode           <= RESET_VALUE[POS_THREAD];
			state.usage_fault_ready     <= RESET_VALUE[POS_USAGE_RDY];
			state.mem_manage_ready      <= RESET_VALUE[POS_MEM_MAN_RDY];
			state.unprivileged          <= RESET_VALUE[POS_UNPRIV];
		end else if (capture) begin
			state.stack_limit_violation <= info.stack_limit_violation;
			state.thread_mode           <= info.thread_mode;
			state.usage_fault_ready     <= info.usage_fault_ready;
			state.mem_manage_ready      <= info.mem_manage_ready;
			state.unprivileged          <= info.unprivileged;
		end else begin
			if (wr_mask[POS_STACK_VIOL])  state.stack_limit_violation <= wdata[POS_STACK_VIOL];
			if (wr_mask[POS_THREAD])      state.thread_mode           <= wdata[POS_THREAD];
			if (wr_mask[POS_USAGE_RDY])   state.usage_fault_ready     <= wdata[POS_USAGE_RDY];
			if (wr_mask[POS_MEM_MAN_RDY]) state.mem_manage_ready      <= wdata[POS_MEM_MAN_RDY];
			if (wr_mask[POS_UNPRIV])      state.unprivileged          <= wdata[POS_UNPRIV];
		end
	end

	// Lazy flag: arming wins over the deferred save finishing and over writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.lazy_save_active <= RESET_VALUE[POS_LAZY_ACTIVE];
		end else if (capture && lazy_arm) begin
			state.lazy_save_active <= 1'b1;
		end else if (lazy_done) begin
			state.lazy_save_active <= 1'b0;
		end else if (wr_mask[POS_LAZY_ACTIVE]) begin
			state.lazy_save_active <= wdata[POS_LAZY_ACTIVE];
		end
	end

endmodule : fp_bank_status

// ### tb/fp_context_control_reg_test.sv
// Self-checking bench for the floating-point context control register.
// Assumes a zero-wait APB slave at FP_CTX_CTRL_OFF and one 25 MHz clock.
`timescale 1ns/10ps
module fp_context_control_reg_test;
	import fp_ctx_pkg::*;
	logic [31:0] prdata, r;
	logic        pclk, presetn, pready, pslverr, e, frame_alloc, frame_secure, fp_instr_exec, exec_secure;
	logic        lazy_save_done, exc_return, fp_context_clear, secure_debug_monitor_enable, bus_fault_ns_enable;
	logic        fp_context_active_flag, clear_caller_regs, lazy_skip_mem, lazy_zero_regs;
	logic        fp_regs_secure, lazy_save_enable_out;
	apb_req_t    apb_req;
	frame_info_t frame_info;
	int          err_total, tests_run;

	fp_context_control_reg fp_context_control_reg_inst (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr,
		.frame_alloc, .frame_secure, .frame_info, .fp_instr_exec, .exec_secure, .lazy_save_done, .exc_return,
		.fp_context_clear, .secure_debug_monitor_enable, .bus_fault_ns_enable, .fp_context_active_flag,
		.clear_caller_regs, .lazy_skip_mem, .lazy_zero_regs, .fp_regs_secure, .lazy_save_enable_out);

	// 25 MHz bus clock
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end

	// Compare and count; x or z in got matches only the same x or z in exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic ns);
		apb_req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d,
			pstrb: 4'hF, pprot: {1'h0, ns, 1'h0}};
		@(posedge pclk);
		apb_req.penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		apb_req.psel <= 1'h0;
		apb_req.penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer

	// Verdict; also reached by the watchdog
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	// Watchdog: the tests need well under 200 cycles
	initial begin
		#(40 * 2000);
		err_total++;
		results();
	end

	initial begin
		presetn = 1'h0;
		apb_req = '0;
		frame_info = '1;
		{frame_alloc, frame_secure, fp_instr_exec, exec_secure, lazy_save_done, exc_return} = '0;
		{fp_context_clear, secure_debug_monitor_enable} = '0;
		bus_fault_ns_enable = 1'h1;
		err_total = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// Reset value, then full Secure write with reserved bits kept zero
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h0);
		chk(r, CTRL_RESET);
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'hFFFFFFFF, 1'h0);
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h0);
		chk(r, 32'hFC0007FF);
		chk({fp_regs_secure, lazy_save_enable_out, lazy_skip_mem, lazy_zero_regs}, 4'hF);
		$display("test secure_view done");
		// Non-secure view hides Secure-only bits; locked bits survive NS write
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h1);
		chk(r, 32'h50000150);
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'h0, 1'h1);
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h0);
		chk(r, 32'hFC0006AF);
		secure_debug_monitor_enable <= 1'h1;
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'hFFFFFFFF, 1'h0);
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h1);
		chk(r, 32'h50000050);
		secure_debug_monitor_enable <= 1'h0;
		$display("test ns_view done");
		// Unmapped word answers with an error and zero data
		xfer(12'h004, 1'h0, 32'h0, 1'h0);
		chk(e, 1'h1);
		chk(r, 32'h0);
		$display("test unmapped done");
		// Auto-preserve sets the active flag; clear on return pulses once
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'h90000000, 1'h0);
		exec_secure <= 1'h1;
		fp_instr_exec <= 1'h1;
		@(posedge pclk);
		fp_instr_exec <= 1'h0;
		exc_return <= 1'h1;
		@(posedge pclk);
		exc_return <= 1'h0;
		#1 chk({fp_context_active_flag, clear_caller_regs}, 2'h3);
		@(posedge pclk);
		#1 chk(clear_caller_regs, 1'h0);
		@(posedge pclk);
		$display("test clear_on_return done");
		// Frame allocation captures readiness, mode and privilege bits
		frame_secure <= 1'h1;
		frame_alloc <= 1'h1;
		@(posedge pclk);
		frame_alloc <= 1'h0;
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h0);
		chk(r, 32'h900007FE);
		$display("test capture done");
		// With auto-preserve off an instruction leaves the flag clear
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'h0, 1'h0);
		fp_context_clear <= 1'h1;
		@(posedge pclk);
		fp_context_clear <= 1'h0;
		fp_instr_exec <= 1'h1;
		@(posedge pclk);
		fp_instr_exec <= 1'h0;
		#1 chk(fp_context_active_flag, 1'h0);
		$display("test auto_off done");
		// Lazy arming: a violation skips the save, a Secure context still zeroes
		@(posedge pclk);
		xfer(FP_CTX_CTRL_OFF, 1'h1, 32'hD4000000, 1'h0);
		fp_instr_exec <= 1'h1;
		@(posedge pclk);
		fp_instr_exec <= 1'h0;
		frame_alloc <= 1'h1;
		@(posedge pclk);
		frame_alloc <= 1'h0;
		exc_return <= 1'h1;
		lazy_save_done <= 1'h1;
		#1 chk({lazy_skip_mem, lazy_zero_regs, fp_context_active_flag}, 3'h7);
		@(posedge pclk);
		exc_return <= 1'h0;
		lazy_save_done <= 1'h0;
		#1 chk({lazy_skip_mem, clear_caller_regs}, 2'h0);
		@(posedge pclk);
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h0);
		chk(r, 32'hD40007FE);
		$display("test lazy done");
		// Without Non-secure fault access the BusFault and HardFault bits read zero
		bus_fault_ns_enable <= 1'h0;
		xfer(FP_CTX_CTRL_OFF, 1'h0, 32'h0, 1'h1);
		chk(r, 32'h50000100);
		$display("test bus_fault_hide done");
		results();
	end
endmodule : fp_context_control_reg_test
